// ---- hw/dual_adc_consts.vh ----
`ifndef DUAL_ADC_CONSTS_VH
`define DUAL_ADC_CONSTS_VH
`define ADC_WIDTH 10
`define CODE_MID 10'h200
`define CODE_POS_FS 10'h3ff
`define CODE_NEG_FS 10'h000
`define CODE_MSB 9
`define CFG_GND 2'h0
`define CFG_THIRD 2'h1
`define CFG_TWO_THIRD 2'h2
`define CFG_FULL 2'h3
`define NAP_RECOVER_CYCLES 100
`define SLEEP_RECOVER_MS 2
`define CLK_HZ 25000000
`define SLEEP_RECOVER_CYCLES ((`SLEEP_RECOVER_MS * `CLK_HZ) / 1000)
`define CNT_WIDTH 17
`define LATENCY_CYCLES 2
`endif

// ---- hw/skid_buffer.v ----
`timescale 1ns/1ps
module skid_buffer (
    input wire i_mclk,
    input wire i_rst,
    input wire i_valid,
    input wire [10:0] i_data,
    output wire o_ready,
    output wire o_valid,
    output wire [10:0] o_data,
    input wire i_ready
);
    reg [10:0] mem_ff [0:1];
    reg wr_ptr_ff;
    reg rd_ptr_ff;
    reg [1:0] count_ff;
    wire push;
    wire pop;
    assign o_ready = (count_ff != 2'h2);
    assign o_valid = (count_ff != 2'h0);
    assign o_data = mem_ff[rd_ptr_ff];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            mem_ff[0] <= 11'h000;
            mem_ff[1] <= 11'h000;
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff <= 2'h0;
        end else begin
            if (push) begin
                mem_ff[wr_ptr_ff] <= i_data;
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 2'h1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 2'h1;
            end
        end
    end
endmodule // skid_buffer

// ---- hw/dual_adc_output_control.v ----
// Behaviour
// - Offset binary: mid 0x200, ends saturate
// - Two's complement: offset code, top bit inverted
// - Overrange raises flag, word clamped full scale
// - Config levels low pick offset, high twos
// - Stabiliser on only at middle levels
// - One config setting drives both channels
// - Enable_n high floats its own bus data and flag, whichever channel feeds it
// - Each channel has its own enable_n
// - Power-down low means normal operation
// - Power-down and enable_n high means sleep
// - Nap keeps reference, recovers in 100 cycles
// - Sleep or nap floats the bus that channel feeds
// - Channel power modes fully independent
// - Swap select high keeps straight routing
// - Swap select low crosses channel buses
// - Stabiliser only raises its flag; sampling always on rising edge
`timescale 1ns/1ps
`include "dual_adc_consts.vh"
module dual_adc_output_control #(
    parameter SLEEP_RECOVER = `SLEEP_RECOVER_CYCLES
) (
    input wire i_mclk,
    input wire i_rst,
    input wire i_chan_a_sample_clock,
    input wire i_chan_b_sample_clock,
    input wire [10:0] i_chan_a_sample,
    input wire [10:0] i_chan_b_sample,
    input wire [1:0] i_config_level,
    input wire i_chan_a_output_enable_n,
    input wire i_chan_b_output_enable_n,
    input wire i_chan_a_power_down,
    input wire i_chan_b_power_down,
    input wire i_bus_swap_select,
    input wire i_bus_a_ready,
    input wire i_bus_b_ready,
    output reg [9:0] o_bus_a_data,
    output reg o_chan_a_overrange,
    output reg o_bus_a_oe,
    output reg o_bus_a_valid,
    output reg [9:0] o_bus_b_data,
    output reg o_chan_b_overrange,
    output reg o_bus_b_oe,
    output reg o_bus_b_valid,
    output reg o_stabiliser_on,
    output reg o_chan_a_asleep,
    output reg o_chan_b_asleep,
    output reg o_chan_a_napping,
    output reg o_chan_b_napping
);
    localparam ST_RUN = 2'h0;
    localparam ST_NAP = 2'h1;
    localparam ST_SLEEP = 2'h2;
    localparam ST_WAKE = 2'h3;
    localparam [`CNT_WIDTH-1:0] NAP_RECOVER = `NAP_RECOVER_CYCLES;

    // Raw sample: bit 10 overrange flag, low 10 bits offset code before clamp.
    // Input encoding: {over, code}; when over, code msb gives direction.
    function [10:0] format_word;
        input [10:0] raw;
        input twos;
        reg [9:0] code;
        begin
            code = raw[9:0];
            if (raw[10]) begin
                code = raw[`CODE_MSB] ? `CODE_POS_FS : `CODE_NEG_FS;
            end
            if (twos) begin
                code[`CODE_MSB] = ~code[`CODE_MSB];
            end
            format_word = {raw[10], code};
        end
    endfunction

    function is_twos;
        input [1:0] lvl;
        begin
            is_twos = (lvl == `CFG_TWO_THIRD) || (lvl == `CFG_FULL);
        end
    endfunction

    function is_stab;
        input [1:0] lvl;
        begin
            is_stab = (lvl == `CFG_THIRD) || (lvl == `CFG_TWO_THIRD);
        end
    endfunction

    // Pin synchronisers, three stages each; first stage read only by second
    wire [7:0] pin_in;
    assign pin_in = {i_chan_a_sample_clock, i_chan_b_sample_clock,
                     i_chan_a_output_enable_n, i_chan_b_output_enable_n,
                     i_chan_a_power_down, i_chan_b_power_down,
                     i_bus_swap_select, 1'b0};
    reg [7:0] s1_ff;
    reg [7:0] s2_ff;
    reg [7:0] s3_ff;
    reg [7:0] pin_ff;
    reg [1:0] cfg1_ff;
    reg [1:0] cfg2_ff;
    reg [1:0] cfg3_ff;
    reg [1:0] cfg_ff;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_sync
            always @(posedge i_mclk or posedge i_rst) begin
                if (i_rst) begin
                    s1_ff[g] <= 1'b0;
                    s2_ff[g] <= 1'b0;
                    s3_ff[g] <= 1'b0;
                    pin_ff[g] <= (g >= 2 && g <= 5) ? 1'b1 : 1'b0;
                end else begin
                    s1_ff[g] <= pin_in[g];
                    s2_ff[g] <= s1_ff[g];
                    s3_ff[g] <= s2_ff[g];
                    if (s2_ff[g] == s3_ff[g]) begin
                        pin_ff[g] <= s3_ff[g];
                    end
                end
            end
        end
    endgenerate

    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cfg1_ff <= `CFG_GND;
            cfg2_ff <= `CFG_GND;
            cfg3_ff <= `CFG_GND;
            cfg_ff <= `CFG_GND;
        end else begin
            cfg1_ff <= i_config_level;
            cfg2_ff <= cfg1_ff;
            cfg3_ff <= cfg2_ff;
            if (cfg2_ff == cfg3_ff) begin
                cfg_ff <= cfg3_ff;
            end
        end
    end

    wire clk_a = pin_ff[7];
    wire clk_b = pin_ff[6];
    wire [1:0] oe_n = {pin_ff[5], pin_ff[4]};
    wire [1:0] pd = {pin_ff[3], pin_ff[2]};
    wire swap_hi = pin_ff[1];
    wire twos = is_twos(cfg_ff);

    // Sample on rising edge only; falling edge ignored in both stabiliser modes
    reg [1:0] clk_d_ff;
    wire [1:0] rise = {clk_a & ~clk_d_ff[1], clk_b & ~clk_d_ff[0]};

    // Per-channel power state machines and latency pipes
    reg [1:0] st_ff [0:1];
    reg [`CNT_WIDTH-1:0] cnt_ff [0:1];
    reg [10:0] pipe0_ff [0:1];
    reg [10:0] pipe1_ff [0:1];
    reg [1:0] pvld_ff [0:1];
    wire [1:0] run;
    wire [10:0] fifo_out [0:1];
    wire [1:0] fifo_vld;
    wire [1:0] fifo_rdy;
    wire [1:0] drain_rdy;
    wire [10:0] raw_in [0:1];
    assign raw_in[0] = i_chan_b_sample;
    assign raw_in[1] = i_chan_a_sample;

    generate
        for (g = 0; g < 2; g = g + 1) begin : g_chan
            // Index 1 is channel A, index 0 channel B; each uses its own pins plus the shared config level
            assign run[g] = (st_ff[g] == ST_RUN);
            always @(posedge i_mclk or posedge i_rst) begin
                if (i_rst) begin
                    st_ff[g] <= ST_SLEEP;
                    cnt_ff[g] <= {`CNT_WIDTH{1'b0}};
                    pipe0_ff[g] <= 11'h000;
                    pipe1_ff[g] <= 11'h000;
                    pvld_ff[g] <= 2'h0;
                end else begin
                    case (st_ff[g])
                        ST_RUN: begin
                            if (pd[g]) begin
                                st_ff[g] <= oe_n[g] ? ST_SLEEP : ST_NAP;
                            end
                        end
                        ST_NAP: begin
                            if (oe_n[g] && pd[g]) begin
                                st_ff[g] <= ST_SLEEP;
                            end else if (!pd[g]) begin
                                st_ff[g] <= ST_WAKE;
                                cnt_ff[g] <= NAP_RECOVER;
                            end
                        end
                        ST_SLEEP: begin
                            if (!pd[g]) begin
                                st_ff[g] <= ST_WAKE;
                                // Reference recharge makes sleep exit slow
                                cnt_ff[g] <= SLEEP_RECOVER[`CNT_WIDTH-1:0];
                            end else if (!oe_n[g]) begin
                                st_ff[g] <= ST_NAP;
                            end
                        end
                        ST_WAKE: begin
                            if (pd[g]) begin
                                st_ff[g] <= oe_n[g] ? ST_SLEEP : ST_NAP;
                            end else if (cnt_ff[g] <= {{(`CNT_WIDTH-1){1'b0}}, 1'b1}) begin
                                st_ff[g] <= ST_RUN;
                            end else begin
                                cnt_ff[g] <= cnt_ff[g] - {{(`CNT_WIDTH-1){1'b0}}, 1'b1};
                            end
                        end
                        default: begin
                            st_ff[g] <= ST_SLEEP;
                        end
                    endcase
                    // Fixed two-stage latency, one word per rising sample edge
                    if (rise[g] && run[g]) begin
                        pipe0_ff[g] <= format_word(raw_in[g], twos);
                        pipe1_ff[g] <= pipe0_ff[g];
                        pvld_ff[g] <= {pvld_ff[g][0], 1'b1};
                    end else if (!run[g]) begin
                        pvld_ff[g] <= 2'h0;
                    end
                end
            end
            // Word pushed only when it leaves the second stage
            skid_buffer u_buf (
                .i_mclk(i_mclk),
                .i_rst(i_rst),
                .i_valid(rise[g] && run[g] && pvld_ff[g][1]),
                .i_data(pipe1_ff[g]),
                .o_ready(fifo_rdy[g]),
                .o_valid(fifo_vld[g]),
                .o_data(fifo_out[g]),
                .i_ready(drain_rdy[g])
            );
        end
    endgenerate

    // Bus side: straight when select high, crossed when low
    wire src_a = swap_hi ? 1'b1 : 1'b0;
    wire [10:0] word_a = src_a ? fifo_out[1] : fifo_out[0];
    wire [10:0] word_b = src_a ? fifo_out[0] : fifo_out[1];
    wire vld_a = src_a ? fifo_vld[1] : fifo_vld[0];
    wire vld_b = src_a ? fifo_vld[0] : fifo_vld[1];
    // Bus drive requires own enable_n low and the channel feeding the bus running
    wire drive_a = !oe_n[1] && run[src_a ? 1 : 0];
    wire drive_b = !oe_n[0] && run[src_a ? 0 : 1];
    // Ready returned to the channel that currently feeds each bus
    wire take_a = vld_a && (i_bus_a_ready || !drive_a);
    wire take_b = vld_b && (i_bus_b_ready || !drive_b);
    assign drain_rdy[1] = src_a ? take_a : take_b;
    assign drain_rdy[0] = src_a ? take_b : take_a;

    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            clk_d_ff <= 2'h0;
            o_bus_a_data <= 10'h000;
            o_chan_a_overrange <= 1'b0;
            o_bus_a_oe <= 1'b0;
            o_bus_a_valid <= 1'b0;
            o_bus_b_data <= 10'h000;
            o_chan_b_overrange <= 1'b0;
            o_bus_b_oe <= 1'b0;
            o_bus_b_valid <= 1'b0;
            o_stabiliser_on <= 1'b0;
            o_chan_a_asleep <= 1'b1;
            o_chan_b_asleep <= 1'b1;
            o_chan_a_napping <= 1'b0;
            o_chan_b_napping <= 1'b0;
        end else begin
            clk_d_ff <= {clk_a, clk_b};
            o_stabiliser_on <= is_stab(cfg_ff);
            o_bus_a_oe <= drive_a;
            o_bus_b_oe <= drive_b;
            o_bus_a_valid <= drive_a && vld_a && i_bus_a_ready;
            o_bus_b_valid <= drive_b && vld_b && i_bus_b_ready;
            // Undriven bus drains silently; its pins keep the last word
            if (take_a && drive_a) begin
                o_bus_a_data <= word_a[9:0];
                o_chan_a_overrange <= word_a[10];
            end
            if (take_b && drive_b) begin
                o_bus_b_data <= word_b[9:0];
                o_chan_b_overrange <= word_b[10];
            end
            o_chan_a_asleep <= (st_ff[1] == ST_SLEEP);
            o_chan_b_asleep <= (st_ff[0] == ST_SLEEP);
            o_chan_a_napping <= (st_ff[1] == ST_NAP);
            o_chan_b_napping <= (st_ff[0] == ST_NAP);
        end
    end
endmodule // dual_adc_output_control

// ---- bench/dual_adc_chk.sv ----
`timescale 1ns/1ps
module dual_adc_chk (
    input wire i_mclk,
    input wire i_rst,
    input wire [1:0] i_config_level,
    input wire i_chan_a_output_enable_n,
    input wire i_chan_b_output_enable_n,
    input wire i_chan_a_power_down,
    input wire i_bus_swap_select,
    input wire o_bus_a_oe,
    input wire o_bus_b_oe,
    input wire o_bus_a_valid,
    input wire [9:0] o_bus_a_data,
    input wire o_chan_a_overrange,
    input wire o_stabiliser_on,
    input wire o_chan_a_asleep,
    input wire o_chan_a_napping
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // Eight cycles cover the three-stage sync plus the state register
    sequence nap_pins_s;
        (i_chan_a_power_down && !i_chan_a_output_enable_n)[*8];
    endsequence
    sequence sleep_pins_s;
        (i_chan_a_power_down && i_chan_a_output_enable_n)[*8];
    endsequence
    sequence straight_s;
        i_bus_swap_select[*8];
    endsequence
    a_stab_tracks: assert property ($stable(i_config_level)[*8] |->
        o_stabiliser_on == (i_config_level == 2'h1 || i_config_level == 2'h2))
        else $error("stabiliser state wrong");
    a_nap_state: assert property (nap_pins_s |-> o_chan_a_napping && !o_chan_a_asleep)
        else $error("nap state wrong");
    a_sleep_state: assert property (sleep_pins_s |-> o_chan_a_asleep && !o_chan_a_napping)
        else $error("sleep state wrong");
    a_nap_floats: assert property ((nap_pins_s and straight_s) |-> !o_bus_a_oe)
        else $error("bus a driven in nap");
    a_sleep_floats: assert property ((sleep_pins_s and straight_s) |-> !o_bus_a_oe)
        else $error("bus a driven in sleep");
    a_enable_a_off: assert property (i_chan_a_output_enable_n[*8] |-> !o_bus_a_oe)
        else $error("bus a driven while disabled");
    a_enable_b_off: assert property (i_chan_b_output_enable_n[*8] |-> !o_bus_b_oe)
        else $error("bus b driven while disabled");
    a_valid_driven: assert property (o_bus_a_valid |-> o_bus_a_oe)
        else $error("word on undriven bus");
    a_word_moves: assert property ($changed({o_chan_a_overrange, o_bus_a_data}) |->
        o_bus_a_valid) else $error("bus a changed without word");
    a_clamp_code: assert property (o_bus_a_valid && o_chan_a_overrange |->
        o_bus_a_data inside {10'h3ff, 10'h000, 10'h1ff, 10'h200})
        else $error("overrange word not clamped");
endmodule // dual_adc_chk
bind dual_adc_output_control dual_adc_chk i_dual_adc_chk (.i_mclk, .i_rst, .i_config_level,
    .i_chan_a_output_enable_n, .i_chan_b_output_enable_n, .i_chan_a_power_down,
    .i_bus_swap_select, .o_bus_a_oe, .o_bus_b_oe, .o_bus_a_valid, .o_bus_a_data,
    .o_chan_a_overrange, .o_stabiliser_on, .o_chan_a_asleep, .o_chan_a_napping);

// ---- bench/capture_model.sv ----
`timescale 1ns/1ps
module capture_model (
    input wire i_mclk,
    input wire i_rst,
    input wire i_stall,
    input wire i_valid,
    input wire i_oe,
    output reg o_ready,
    output reg [15:0] o_count
);
    reg [7:0] lfsr_ff;
    // Ready follows a pseudo-random LFSR bit so the buffer really has to hold words
    always @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            lfsr_ff <= 8'h5a;
            o_ready <= 1'b0;
            o_count <= 16'h0000;
        end else begin
            lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
            o_ready <= !i_stall && lfsr_ff[0];
            // Undriven bus is Hi-Z, so nothing is latched from it
            if (i_valid && i_oe) begin
                o_count <= o_count + 16'h0001;
            end
        end
    end
endmodule // capture_model

// ---- bench/dual_adc_output_control_tb_top.sv ----
`timescale 1ns/1ps
module dual_adc_output_control_tb_top;
    localparam int SR = 10;
    reg i_mclk, i_rst, sclk, oen_a, oen_b, pd_a, pd_b, swap, stall;
    reg [10:0] sa, sb;
    reg [1:0] cfg;
    reg [31:0] rng;
    reg [3:0] sdiv;
    reg [10:0] tv [0:5];
    wire [9:0] da, db;
    wire fa, fb, chan_a_output_enable_n, chan_b_output_enable_n, va, vb, stab, sl_a, sl_b, np_a, np_b, rdy_a, rdy_b;
    wire [15:0] cnt_a, cnt_b;
    integer mismatches, num_checks, n, k, w;
    dual_adc_output_control #(.SLEEP_RECOVER(SR)) i_dual_adc_output_control (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_chan_a_sample_clock(sclk),
        .i_chan_b_sample_clock(sclk),
        .i_chan_a_sample(sa), .i_chan_b_sample(sb),
        .i_config_level(cfg), .i_chan_a_output_enable_n(oen_a),
        .i_chan_b_output_enable_n(oen_b), .i_chan_a_power_down(pd_a),
        .i_chan_b_power_down(pd_b), .i_bus_swap_select(swap), .i_bus_a_ready(rdy_a),
        .i_bus_b_ready(rdy_b), .o_bus_a_data(da), .o_chan_a_overrange(fa), .o_bus_a_oe(chan_a_output_enable_n),
        .o_bus_a_valid(va), .o_bus_b_data(db), .o_chan_b_overrange(fb), .o_bus_b_oe(chan_b_output_enable_n),
        .o_bus_b_valid(vb), .o_stabiliser_on(stab), .o_chan_a_asleep(sl_a),
        .o_chan_b_asleep(sl_b), .o_chan_a_napping(np_a), .o_chan_b_napping(np_b));
    capture_model i_capture_model_a (.i_mclk(i_mclk), .i_rst(i_rst), .i_stall(stall),
        .i_valid(va), .i_oe(chan_a_output_enable_n), .o_ready(rdy_a), .o_count(cnt_a));
    capture_model i_capture_model_b (.i_mclk(i_mclk), .i_rst(i_rst), .i_stall(stall),
        .i_valid(vb), .i_oe(chan_b_output_enable_n), .o_ready(rdy_b), .o_count(cnt_b));
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction
    // Raw is {over, offset code}; over clamps toward the sign of the code
    function [10:0] fmt(input [10:0] r, input [1:0] c);
        reg [9:0] v;
        begin
            v = r[10] ? {10{r[9]}} : r[9:0];
            fmt = {r[10], v ^ {c[1], 9'h000}};
        end
    endfunction
    task chk(input string nm, input [10:0] e, input [10:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                mismatches = mismatches + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task cyc(input integer c);
        repeat (c) @(negedge i_mclk);
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", num_checks, mismatches);
            if (mismatches == 0 && num_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    task wait_oe;
        begin
            n = 0;
            while (chan_a_output_enable_n !== 1'b1 && n < 300) begin
                @(negedge i_mclk);
                n = n + 1;
            end
        end
    endtask
    initial begin
        i_mclk = 0;
        forever #20 i_mclk = ~i_mclk;
    end
    // Sample clock at a tenth of the system clock, five high and five low
    always @(posedge i_mclk) begin
        sdiv <= (sdiv == 4'h9) ? 4'h0 : sdiv + 4'h1;
        sclk <= (sdiv < 4'h5);
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        mismatches = mismatches + 1;
        summarize;
    end
    initial begin
        {i_rst, sclk, sdiv, oen_a, oen_b, pd_a, pd_b, swap, stall} = {2'b10, 4'h0, 6'h02};
        {sa, sb, cfg, rng} = {11'h200, 11'h200, 2'h0, 32'd80179};
        {tv[0], tv[1], tv[2], tv[3], tv[4], tv[5]} = {11'h200, 11'h3ff, 11'h000,
            11'h1ff, 11'h600, 11'h400};
        mismatches = 0;
        num_checks = 0;
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
        for (k = 0; k < 64; k = k + 1) begin
            rng = xs(rng);
            @(posedge i_mclk);
            {swap, cfg} <= k[2:0];
            sa <= (k[5:3] > 5) ? {1'b0, rng[9:0]} : tv[k[5:3]];
            sb <= {rng[20], rng[19:10]};
            cyc(72);
            chk("bus_a", fmt(k[2] ? sa : sb, k[1:0]), {fa, da});
            chk("bus_b", fmt(k[2] ? sb : sa, k[1:0]), {fb, db});
            chk("stab", k[1:0] == 1 || k[1:0] == 2, stab);
        end
        $display("test format done");
        w = cnt_a;
        cyc(200);
        chk("rate", 1, cnt_a - w >= 19 && cnt_a - w <= 21);
        @(posedge i_mclk);
        stall <= 1'b1;
        cyc(5);
        w = cnt_a;
        cyc(60);
        chk("stalled", w, cnt_a);
        @(posedge i_mclk);
        stall <= 1'b0;
        cyc(20);
        chk("drained", 1, cnt_a - w >= 2);
        $display("test buffer done");
        // Enables are moved while the sample clock keeps running and words keep flowing
        @(posedge i_mclk);
        oen_b <= 1'b1;
        cyc(12);
        chk("oe_b_off", 3'b000, {chan_b_output_enable_n, sl_b, np_b});
        @(posedge i_mclk);
        swap <= 1'b0;
        cyc(12);
        chk("oe_cross", 2'b10, {chan_a_output_enable_n, chan_b_output_enable_n});
        @(posedge i_mclk);
        {swap, oen_b, pd_a} <= 3'b101;
        cyc(12);
        chk("nap", 4'b1001, {np_a, sl_a, chan_a_output_enable_n, chan_b_output_enable_n});
        @(posedge i_mclk);
        pd_a <= 1'b0;
        wait_oe;
        chk("nap_exit", 1, n >= 100 && n <= 130);
        @(posedge i_mclk);
        {pd_a, oen_a} <= 2'b11;
        cyc(12);
        chk("sleep", 4'b1001, {sl_a, np_a, chan_a_output_enable_n, chan_b_output_enable_n});
        @(posedge i_mclk);
        {pd_a, oen_a} <= 2'b00;
        wait_oe;
        chk("sleep_exit", 1, n >= SR && n <= SR + 30);
        $display("test power done");
        summarize;
    end
endmodule // dual_adc_output_control_tb_top
